// [rtl/icm_cascade_ctrl.v]
// Eight-input priority interrupt controller core with cascading,
// end-of-interrupt commands and normal and special masking.
// Assumes an AXI4-Lite master on clk, and acknowledge pulses from the host
// arriving as one-cycle strobes on clk; all inputs are synchronous to clk.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "icm_consts.vh"

// What this block does
// - Buffer enable active while data outputs drive.
// - Buffered mode: role bit picks master/slave.
// - Eight slaves by eight inputs, 64 levels.
// - Selected slave drives vector on later acknowledges.
// - Cascade bus low except for slave inputs.
// - Hold slave address first to last acknowledge.
// - Each slave configured independently, same auto-end.
// - Non-slave input: bus low, master gives vector.
// - Slave input: interrupt if priority, output number.
// - Slave raises interrupt for unblocked peripheral request.
// - Slave matches cascade address, acts stand-alone.
// - Auto-end clears in-service bit on final acknowledge.
// - Non-specific end clears highest in-service bit.
// - Decode end commands from bits seven to five.
// - Specific end clears exactly the named bit.
// - Mask write disables only its own inputs.
// - Special mask: masked levels blocked, their in-service bits block nothing.
// - Special mask entered/left only with enable set.
// - Role bit ignored unless buffered mode set.
// - Fixed priority, input zero highest, seven lowest.
module icm_cascade_ctrl
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // AXI4-Lite register slave.
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt requests and host handshake.
  input wire [7:0] requestInputs,
  output reg intOut,
  input wire acknowledgePulse,
  // Data bus toward the host, through external buffers.
  output reg [7:0] dataOut,
  output reg dataOutEn,
  output wire bufferEnableOut_n,
  // Cascade address bus: input, output, output enable (low drives).
  input wire [2:0] cascadeAddressBusIn,
  output reg [2:0] cascadeAddressBusOut,
  output reg cascadeAddressBusOe_n,
  // Role strap used when not buffered, and base vector.
  input wire masterStrap,
  input wire [4:0] vectorBase
);

  // States of the acknowledge sequence, one-hot.
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ACK1 = 4'h2;
  localparam [3:0] ST_ACK2 = 4'h4;
  localparam [3:0] ST_ACK3 = 4'h8;

  reg [7:0] maskBits_q;
  reg [7:0] inServiceBits_q;
  reg [7:0] config_q;
  reg [7:0] thirdInitWord_q;
  reg specialMask_q;
  reg [3:0] state_q;
  reg [2:0] ackLevel_q;
  reg ackDelegated_q;
  reg [4:0] awAddr_q;
  reg awHeld_q;
  reg [31:0] wData_q;
  reg wHeld_q;
  reg [4:0] wrAddr;
  reg [31:0] wrData;
  reg doWrite;

  // Mode decode; the role bit only counts when buffered.
  wire standaloneFlag = config_q[`ICM_CFG_SINGLE];
  wire bufferedMode = config_q[`ICM_CFG_BUFFERED];
  wire isMaster = bufferedMode ? config_q[`ICM_CFG_ROLE] : masterStrap;
  wire cascMaster = !standaloneFlag && isMaster;
  wire cascSlave = !standaloneFlag && !isMaster;
  wire vectorMode = config_q[`ICM_CFG_VECTOR];
  wire autoEoi = config_q[`ICM_CFG_AUTOEOI];
  wire [2:0] slaveId = thirdInitWord_q[2:0];

  // Requests enabled by the mask, and in-service bits that still block.
  // In special mask mode a masked level hides its in-service bit, so
  // a lower level may interrupt unless a higher unmasked level is in service.
  wire [7:0] enabledReq = requestInputs & ~maskBits_q;
  wire [7:0] blockingIsr = specialMask_q ? (inServiceBits_q & ~maskBits_q)
                                         : inServiceBits_q;

  // Fixed priority scan: lowest index wins.
  reg [2:0] reqLevel;
  reg reqFound;
  reg [2:0] isrLevel;
  reg isrFound;
  reg [2:0] blkLevel;
  reg blkFound;
  integer i;
  always @*
  begin
    reqLevel = 3'h0;
    reqFound = 1'b0;
    isrLevel = 3'h0;
    isrFound = 1'b0;
    blkLevel = 3'h0;
    blkFound = 1'b0;
    for (i = 7; i >= 0; i = i - 1)
    begin
      if (enabledReq[i])
      begin
        reqLevel = i[2:0];
        reqFound = 1'b1;
      end
      if (inServiceBits_q[i])
      begin
        isrLevel = i[2:0];
        isrFound = 1'b1;
      end
      if (blockingIsr[i])
      begin
        blkLevel = i[2:0];
        blkFound = 1'b1;
      end
    end
  end

  // A request wins only above every blocking in-service level.
  wire reqWins = reqFound && (!blkFound || reqLevel < blkLevel);

  // Interrupt output is registered; held low while a cycle runs.
  always @(posedge clk)
  begin
    if (rst)
      intOut <= 1'b0;
    else
      intOut <= reqWins && (state_q == ST_IDLE);
  end

  // AXI write channels are captured independently, in either order.
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire haveAw = awHeld_q || awFire;
  wire haveW = wHeld_q || wFire;
  always @*
  begin
    wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
    wrData = wHeld_q ? wData_q : s_axi_wdata;
    doWrite = haveAw && haveW && !s_axi_bvalid;
  end
  wire wrLane0 = (wHeld_q || wFire) && s_axi_wstrb[0];
  wire wrMapped = (wrAddr <= `ICM_OFF_REQ) && (wrAddr[1:0] == 2'h0);

  always @(posedge clk)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 5'h00;
      wData_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ICM_RESP_OKAY;
    end
    else
    begin
      if (awFire && !doWrite)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wFire && !doWrite)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Decoded command strobes; byte lane 0 carries every register.
  wire wrEn = doWrite && wrLane0;
  wire wrMask = wrEn && wrAddr == `ICM_OFF_MASK;
  wire wrEoi = wrEn && wrAddr == `ICM_OFF_EOI;
  wire wrOpw3 = wrEn && wrAddr == `ICM_OFF_OPW3;
  wire [2:0] eoiCmd = wrData[7:5];
  wire [2:0] levelField = wrData[2:0];
  wire eoiSpecific = wrEoi && wrData[4:3] == 2'h0 &&
                     (eoiCmd == `ICM_CMD_SEOI || eoiCmd == `ICM_CMD_RSEOI);
  wire eoiNonSpecific = wrEoi && wrData[4:3] == 2'h0 &&
                        (eoiCmd == `ICM_CMD_NSEOI || eoiCmd == `ICM_CMD_RNSEOI);

  // Configuration, mask and special mask mode.
  always @(posedge clk)
  begin
    if (rst)
    begin
      maskBits_q <= `ICM_MASK_RST;
      config_q <= `ICM_CFG_RST;
      thirdInitWord_q <= `ICM_CFG3_RST;
      specialMask_q <= 1'b0;
    end
    else
    begin
      if (wrMask)
        maskBits_q <= wrData[7:0];
      if (wrEn && wrAddr == `ICM_OFF_CFG)
        config_q <= {3'h0, wrData[4:0]};
      if (wrEn && wrAddr == `ICM_OFF_CFG3)
        thirdInitWord_q <= wrData[7:0];
      if (wrOpw3 && wrData[`ICM_OPW3_SMEN])
        specialMask_q <= wrData[`ICM_OPW3_SMSET];
    end
  end

  // Acknowledge sequence. The first pulse picks the level and, except in a
  // cascade slave, sets its in-service bit; a master with a slave on that
  // level hands the remaining pulses to that slave over the cascade bus.
  wire lastAck2 = vectorMode;
  wire addrMatch = cascadeAddressBusIn == slaveId;
  // A slave can only see its address at the second pulse, since the master
  // raises it after the first; an unnamed slave stays silent to the end.
  wire slaveSel = cascSlave && addrMatch && state_q == ST_ACK1;
  wire slaveOnReq = thirdInitWord_q[reqLevel] && cascMaster;
  wire ackLast = acknowledgePulse &&
                 ((state_q == ST_ACK1 && lastAck2) || state_q == ST_ACK2);
  reg [7:0] isrSet;
  reg [7:0] isrClr;
  always @*
  begin
    isrSet = 8'h00;
    isrClr = 8'h00;
    if (acknowledgePulse && state_q == ST_IDLE && reqFound && !cascSlave)
      isrSet[reqLevel] = 1'b1;
    // A selected slave in vector mode with auto-end leaves its bit clear.
    if (acknowledgePulse && slaveSel && enabledReq[ackLevel_q] && !(autoEoi && lastAck2))
      isrSet[ackLevel_q] = 1'b1;
    if (eoiSpecific)
      isrClr[levelField] = 1'b1;
    else if (eoiNonSpecific && isrFound)
      isrClr[isrLevel] = 1'b1;
    if (autoEoi && ackLast && !(cascSlave && ackDelegated_q && !slaveSel))
      isrClr[ackLevel_q] = 1'b1;
  end

  // A bit set by a fresh acknowledge survives a clear in the same cycle.
  always @(posedge clk)
  begin
    if (rst)
      inServiceBits_q <= 8'h00;
    else
      inServiceBits_q <= (inServiceBits_q & ~isrClr) | isrSet;
  end

  // Sequence state, data output and cascade bus.
  always @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      ackLevel_q <= 3'h0;
      ackDelegated_q <= 1'b0;
      dataOut <= 8'h00;
      dataOutEn <= 1'b0;
      cascadeAddressBusOut <= 3'h0;
      cascadeAddressBusOe_n <= 1'b1;
    end
    else
    begin
      dataOutEn <= 1'b0;
      // Master drives the bus, low by default; slaves only listen.
      cascadeAddressBusOe_n <= !cascMaster;
      case (state_q)
        ST_IDLE:
        begin
          cascadeAddressBusOut <= 3'h0;
          if (acknowledgePulse)
          begin
            state_q <= ST_ACK1;
            ackLevel_q <= reqLevel;
            // A slave stays silent until the cascade bus names it.
            ackDelegated_q <= slaveOnReq || cascSlave;
            if (slaveOnReq)
              cascadeAddressBusOut <= reqLevel;
            // In call mode the master gives the first byte itself, even for a slave input.
            if (!cascSlave)
            begin
              dataOut <= 8'hcd; // Call opcode on the first byte.
              dataOutEn <= !vectorMode;
            end
          end
        end
        ST_ACK1:
          if (acknowledgePulse)
          begin
            dataOut <= {vectorBase, ackLevel_q};
            dataOutEn <= !ackDelegated_q || slaveSel;
            ackDelegated_q <= ackDelegated_q && !slaveSel;
            state_q <= lastAck2 ? ST_IDLE : ST_ACK2;
            if (lastAck2)
              cascadeAddressBusOut <= 3'h0;
          end
        ST_ACK2:
          if (acknowledgePulse)
          begin
            dataOut <= 8'h00; // Upper address byte of the call.
            dataOutEn <= !ackDelegated_q;
            state_q <= ST_IDLE;
            cascadeAddressBusOut <= 3'h0;
          end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Buffers are enabled exactly while data is driven, in buffered mode;
  // otherwise the pin stays inactive.
  assign bufferEnableOut_n = !(bufferedMode && dataOutEn);

  // Read channel: one outstanding read, answered the cycle after arvalid.
  assign s_axi_arready = !s_axi_rvalid;
  wire rdMapped = (s_axi_araddr <= `ICM_OFF_REQ) && (s_axi_araddr[1:0] == 2'h0);
  reg [7:0] rdByte;
  always @*
  begin
    case (s_axi_araddr)
      `ICM_OFF_MASK: rdByte = maskBits_q;
      `ICM_OFF_OPW3: rdByte = {1'b0, 1'b0, specialMask_q, 5'h00};
      `ICM_OFF_CFG: rdByte = config_q;
      `ICM_OFF_CFG3: rdByte = thirdInitWord_q;
      `ICM_OFF_STAT: rdByte = inServiceBits_q;
      `ICM_OFF_REQ: rdByte = requestInputs;
      default: rdByte = 8'h00;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ICM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rdByte};
      s_axi_rresp <= rdMapped ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // icm_cascade_ctrl

// [rtl/icm_consts.vh]
// Constants of the cascade-capable interrupt controller core.
// Included by the design file and the bench; holds definitions and nothing else.
`ifndef ICM_CONSTS_VH
`define ICM_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define ICM_OFF_MASK 5'h00
`define ICM_OFF_EOI 5'h04
`define ICM_OFF_OPW3 5'h08
`define ICM_OFF_CFG 5'h0c
`define ICM_OFF_CFG3 5'h10
`define ICM_OFF_STAT 5'h14
`define ICM_OFF_REQ 5'h18

// Reset values.
`define ICM_MASK_RST 8'h00
`define ICM_CFG_RST 8'h01
`define ICM_CFG3_RST 8'h00

// Configuration register fields (first and fourth init words merged).
`define ICM_CFG_SINGLE 0
`define ICM_CFG_VECTOR 1
`define ICM_CFG_AUTOEOI 2
`define ICM_CFG_ROLE 3
`define ICM_CFG_BUFFERED 4

// Second operation word command codes in bits 7..5.
`define ICM_CMD_NSEOI 3'h1
`define ICM_CMD_SEOI 3'h3
`define ICM_CMD_RNSEOI 3'h5
`define ICM_CMD_RSEOI 3'h7

// Third operation word fields.
`define ICM_OPW3_SMSET 5
`define ICM_OPW3_SMEN 6

// AXI responses.
`define ICM_RESP_OKAY 2'h0
`define ICM_RESP_SLVERR 2'h2

`endif

// [tb/icm_cascade_asserts.sv]
// Checker for the cascade interrupt core: cascade timing and bus handshakes.
// Assumes binding to the core and sight of its ports only.
`timescale 1ns/10ps
module icm_cascade_asserts
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Watched core ports.
  input wire acknowledgePulse,
  input wire dataOutEn,
  input wire bufferEnableOut_n,
  input wire [2:0] cascadeAddressBusOut,
  input wire cascadeAddressBusOe_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The cascade bus and the data byte may only move just after an acknowledge.
  sequence s_ackRecent;
    $past(acknowledgePulse) || $past(acknowledgePulse, 2);
  endsequence
  sequence s_casLeave;
    $past(cascadeAddressBusOut) != 3'h0 && $changed(cascadeAddressBusOut);
  endsequence
  sequence s_casStart;
    $past(cascadeAddressBusOut) == 3'h0 && $changed(cascadeAddressBusOut);
  endsequence

  a_buf_en_drive: assert property (!bufferEnableOut_n |-> dataOutEn)
    else $error("buffer enable active with no driven byte");
  a_cas_driven: assert property (cascadeAddressBusOut != 3'h0 |-> !cascadeAddressBusOe_n)
    else $error("cascade address shown while not driven");
  a_cas_start: assert property (s_casStart |-> s_ackRecent)
    else $error("cascade address raised without acknowledge");
  a_cas_hold: assert property (s_casLeave |-> s_ackRecent)
    else $error("cascade address dropped between acknowledges");
  a_data_cause: assert property (dataOutEn |-> s_ackRecent)
    else $error("data byte driven without acknowledge");
  a_data_pulse: assert property (dataOutEn |=> !dataOutEn)
    else $error("data byte held longer than one cycle");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response withdrawn");
  a_rresp_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response withdrawn");
endmodule // icm_cascade_asserts

bind icm_cascade_ctrl icm_cascade_asserts u_icmChk (.*);

// [tb/icm_slave_model.sv]
// Behavioural slave controller wired to one master request input.
// Assumes the bench resolves the cascade wire and strobes acknowledges.
`timescale 1ns/10ps
module icm_slave_model
#(
  parameter [2:0] SLAVE_ID = 3'h3 // Nonzero: an idle bus never selects it.
)
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Bench control and cascade view.
  input wire raise,
  input wire ack,
  input wire [2:0] casWire,
  // Toward the master.
  output reg slaveInt_q,
  output reg hit_q
);
  // The request stays up until this slave is addressed; later bytes are only noted.
  always @(posedge clk)
  begin
    if (rst)
    begin
      slaveInt_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      slaveInt_q <= raise && !hit_q;
      if (ack && raise && casWire == SLAVE_ID)
        hit_q <= 1'b1;
    end
  end
endmodule // icm_slave_model

// [tb/tb.sv]
// Self-checking bench for the cascade interrupt core.
// Assumes icm_consts.vh on the include path.
`timescale 1ns/10ps
`include "icm_consts.vh"
module tb;
  // Core-facing signals, named as its ports.
  reg clk = 0;
  reg rst = 1;
  reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0;
  reg [3:0] s_axi_wstrb = 4'h1;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0, raise = 0, acknowledgePulse = 0, masterStrap = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg [7:0] reqs = 0;
  reg [4:0] vectorBase = 5'h15;
  reg [2:0] casDrive = 3'h0;
  wire intOut, dataOutEn, bufferEnableOut_n, cascadeAddressBusOe_n, slaveInt_q, hit_q;
  wire [7:0] dataOut;
  wire [2:0] cascadeAddressBusOut;
  bit bufMode = 0;
  int n_mismatch = 0, n_tests = 0;
  // Slave request enters input 3; a released cascade wire shows the outside master.
  wire [7:0] requestInputs = reqs | {4'h0, slaveInt_q, 3'h0};
  wire [2:0] cascadeAddressBusIn = cascadeAddressBusOe_n ? casDrive : cascadeAddressBusOut;

  // Clock.
  always #10 clk = ~clk;

  icm_cascade_ctrl i_dut (.*);
  icm_slave_model i_slave (.clk(clk), .rst(rst), .raise(raise), .ack(acknowledgePulse),
    .casWire(cascadeAddressBusIn), .slaveInt_q(slaveInt_q), .hit_q(hit_q));

  task end_sim;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      n_tests++;
      if (s !== e)
      begin
        n_mismatch++;
        $display("unexpected %s: expected %h seen %h", n, e, s);
      end
    end
  endtask

  // One bus access; each channel is released only at the edge that takes it.
  task xfer(input w, input [4:0] a, input [7:0] d, input [1:0] er, input [7:0] eq);
    int k;
    logic ta, tw, td;
    begin
      td = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (k = 0; k < 40 && td !== 1; k++)
      begin
        #5;
        ta = w ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
        tw = s_axi_wvalid && s_axi_wready;
        td = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
        if (td === 1)
          chk("resp", er, w ? s_axi_bresp : s_axi_rresp);
        if (td === 1 && !w && er == 0)
          chk("rdata", eq, s_axi_rdata);
        @(posedge clk);
        if (ta === 1)
        begin
          s_axi_awvalid <= 0;
          s_axi_arvalid <= 0;
        end
        if (tw === 1)
          s_axi_wvalid <= 0;
        if (td === 1)
        begin
          s_axi_bready <= 0;
          s_axi_rready <= 0;
        end
      end
      if (td !== 1)
      begin
        n_mismatch++;
        end_sim;
      end
    end
  endtask

  // One acknowledge pulse; the byte may land one or two edges later.
  task ack(input [7:0] ed, input ee);
    bit seen;
    begin
      @(posedge clk);
      acknowledgePulse <= 1;
      @(posedge clk);
      acknowledgePulse <= 0;
      #5 seen = dataOutEn === 1;
      if (!seen)
      begin
        @(posedge clk);
        #5 seen = dataOutEn === 1;
      end
      chk("dataOutEn", ee, seen);
      if (seen)
        chk("bufferEnableOut_n", !bufMode, bufferEnableOut_n);
      if (ee)
        chk("dataOut", ed, dataOut);
      @(posedge clk);
    end
  endtask

  // Looks a little after each edge, and returns on an edge.
  task waitInt(input e);
    int k;
    begin
      #5;
      for (k = 0; k < 20 && intOut !== e; k++)
      begin
        @(posedge clk);
        #5;
      end
      chk("intOut", e, intOut);
      if (intOut !== e)
        end_sim;
      @(posedge clk);
    end
  endtask

  // Call mode service: call byte, vector, trailing zero.
  task svc(input [2:0] l);
    begin
      ack(8'hcd, 1);
      ack({vectorBase, l}, 1);
      ack(8'h00, 1);
    end
  endtask

  task t_resetMask;
    begin
      xfer(0, `ICM_OFF_CFG, 0, `ICM_RESP_OKAY, `ICM_CFG_RST);
      xfer(0, 5'h1c, 0, `ICM_RESP_SLVERR, 0);
      xfer(1, `ICM_OFF_MASK, 8'h04, 0, 0);
      xfer(0, `ICM_OFF_MASK, 0, 0, 8'h04);
      reqs <= 8'h04;
      repeat (4) @(posedge clk);
      #5 chk("intOut", 0, intOut);
      @(posedge clk);
      reqs <= 8'h0c;
      waitInt(1);
      reqs <= 0;
      xfer(1, `ICM_OFF_MASK, 8'h00, 0, 0);
    end
  endtask

  task t_nest;
    begin
      reqs <= 8'h20;
      waitInt(1);
      svc(5);
      reqs <= 8'h22;
      waitInt(1);
      svc(1);
      reqs <= 0;
      xfer(1, `ICM_OFF_EOI, 8'h20, 0, 0);
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h20);
      xfer(1, `ICM_OFF_EOI, 8'h66, 0, 0);
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h20);
      xfer(1, `ICM_OFF_EOI, 8'h65, 0, 0);
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
    end
  endtask

  // Every end command code on level 4 must empty the in-service set.
  task t_codes;
    int i;
    begin
      for (i = 0; i < 4; i++)
      begin
        reqs <= 8'h10;
        waitInt(1);
        svc(4);
        reqs <= 0;
        xfer(1, `ICM_OFF_EOI, {i[1:0], 6'h24}, 0, 0);
        xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
      end
    end
  endtask

  task t_auto_end_of_interrupt;
    begin
      xfer(1, `ICM_OFF_CFG, 8'h07, 0, 0);
      reqs <= 8'h08;
      waitInt(1);
      ack(0, 0);
      ack({vectorBase, 3'h3}, 1);
      reqs <= 0;
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
    end
  endtask

  task t_casc;
    begin
      bufMode = 1;
      xfer(1, `ICM_OFF_CFG, 8'h18, 0, 0);
      xfer(1, `ICM_OFF_CFG3, 8'h08, 0, 0);
      raise <= 1;
      waitInt(1);
      ack(8'hcd, 1);
      @(posedge clk);
      #5 chk("casOut", 3, cascadeAddressBusOut);
      chk("casOe_n", 0, cascadeAddressBusOe_n);
      ack(0, 0);
      #5 chk("casOut", 3, cascadeAddressBusOut);
      ack(0, 0);
      repeat (2) @(posedge clk);
      #5 chk("casOut", 0, cascadeAddressBusOut);
      chk("slaveHit", 1, hit_q);
      raise <= 0;
      xfer(1, `ICM_OFF_EOI, 8'h20, 0, 0);
      reqs <= 8'h01;
      waitInt(1);
      ack(8'hcd, 1);
      @(posedge clk);
      #5 chk("casOut", 0, cascadeAddressBusOut);
      ack({vectorBase, 3'h0}, 1);
      ack(0, 1);
      reqs <= 0;
      xfer(1, `ICM_OFF_EOI, 8'h20, 0, 0);
      bufMode = 0;
      xfer(1, `ICM_OFF_CFG, 8'h01, 0, 0);
    end
  endtask

  // Core as buffered slave 5: an outside master names slave 2, then slave 5.
  task t_slave;
    begin
      bufMode = 1;
      xfer(1, `ICM_OFF_CFG, 8'h10, 0, 0);
      xfer(1, `ICM_OFF_CFG3, 8'h05, 0, 0);
      reqs <= 8'h40;
      waitInt(1);
      ack(0, 0);
      casDrive <= 3'h2;
      ack(0, 0);
      ack(0, 0);
      casDrive <= 3'h0;
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
      waitInt(1);
      ack(0, 0);
      casDrive <= 3'h5;
      ack({vectorBase, 3'h6}, 1);
      ack(8'h00, 1);
      casDrive <= 3'h0;
      reqs <= 0;
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h40);
      xfer(1, `ICM_OFF_EOI, 8'h20, 0, 0);
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
      bufMode = 0;
      xfer(1, `ICM_OFF_CFG, 8'h01, 0, 0);
    end
  endtask

  task t_smm;
    begin
      reqs <= 8'h04;
      waitInt(1);
      svc(2);
      xfer(1, `ICM_OFF_MASK, 8'h04, 0, 0);
      xfer(1, `ICM_OFF_OPW3, 8'h60, 0, 0);
      xfer(0, `ICM_OFF_OPW3, 0, 0, 8'h20);
      reqs <= 8'h24;
      waitInt(1);
      xfer(1, `ICM_OFF_OPW3, 8'h20, 0, 0);
      xfer(0, `ICM_OFF_OPW3, 0, 0, 8'h20);
      xfer(1, `ICM_OFF_OPW3, 8'h40, 0, 0);
      xfer(0, `ICM_OFF_OPW3, 0, 0, 8'h00);
      repeat (4) @(posedge clk);
      #5 chk("intOut", 0, intOut);
      xfer(1, `ICM_OFF_EOI, 8'h62, 0, 0);
      xfer(0, `ICM_OFF_STAT, 0, 0, 8'h00);
    end
  endtask

  // Reset, then the scenarios in order.
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_resetMask;
    t_nest;
    t_codes;
    t_auto_end_of_interrupt;
    xfer(1, `ICM_OFF_CFG, 8'h01, 0, 0);
    t_casc;
    t_slave;
    t_smm;
    end_sim;
  end
endmodule // tb
